// File: sim/host_model.sv
// Host processor model: reads flags on interrupt, forwards cycle writes
`timescale 1ns/1ps
`include "supervisor_params.svh"
module host_model (
  input wire logic sys_clk,
  input wire logic read_en,
  input wire logic swpc_go,
  input wire logic interrupt_out_n,
  input wire logic [`NUM_FAULTS-1:0] fault_flags,
  output logic [`NUM_FAULTS-1:0] fault_read,
  output logic sw_power_cycle_req_wr,
  output logic i2c_activity
);
  logic go_ff;
  logic [1:0] poll_ff;
  initial begin
    go_ff = 1'b0;
    poll_ff = 2'h0;
    fault_read = '0;
    sw_power_cycle_req_wr = 1'b0;
  end
  always @(posedge sys_clk) go_ff <= swpc_go;
  // Polls slowly on purpose, so a still-present condition is read repeatedly
  always @(negedge sys_clk) begin
    poll_ff <= poll_ff + 2'h1;
    fault_read <= (read_en && !interrupt_out_n && poll_ff == 2'h0) ?
                  fault_flags : '0;
    sw_power_cycle_req_wr <= go_ff;
  end
  assign i2c_activity = |fault_read | sw_power_cycle_req_wr;
endmodule

// File: sim/testbench.sv
// Self-checking bench for the system supervisor
`timescale 1ns/1ps
`include "supervisor_params.svh"
module testbench import supervisor_pkg::*;;
  localparam int MSC = 1;
  logic sys_clk, sys_rst, pb_n, low_imp, rail_low, ocp, ovp, sw_ss;
  logic en, uv, flt, wsr, wpc;
  logic [3:0] pin_exp;
  logic buck_lim, buck_cyc, ldo_lim, swpc_go, read_en, wr, act;
  logic req, oe, rst_n, sw_close, warn, irq_n;
  logic [1:0] hold_sel, pin_sel;
  logic [3:0] gp_out, gp_oe_n;
  logic [`NUM_FAULTS-1:0] mask, rd, flags;
  pwr_state_t state;
  int fails, tests_run, hold;
  int hold_ms[4] = '{32, 500, 1000, 2000};
  logic [31:0] seed = 32'h0001_18ea;

  pmic_system_supervisor #(.MS_CYCLES(MSC), .OV_DEGLITCH_CYC(8),
    .LDO_ILIM_CYC(8), .BUCK_ILIM_CYCLES(8)) i_pmic_system_supervisor (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(en),
    .pushbutton_in_n(pb_n), .press_low_imp(low_imp),
    .system_rail_below_warn(rail_low), .vin_overcurrent(ocp),
    .vin_overvoltage(ovp), .vin_undervoltage(uv),
    .input_switch_ss_done(sw_ss), .buck_ilim(buck_lim),
    .buck_sw_cycle(buck_cyc), .buck_ss_done(1'b1), .ldo_ilim(ldo_lim),
    .ldo_ss_done(1'b1), .output_fault(flt),
    .press_hold_time_sel(hold_sel), .sw_power_cycle_req_wr(wr),
    .wdt_soft_reset_en(wsr), .wdt_power_cycle_en(wpc),
    .i2c_activity(act), .fault_mask(mask), .fault_read(rd),
    .irq_pin_sel(pin_sel), .sw_power_cycle_req(req), .power_state(state),
    .outputs_enable(oe), .system_reset_out_n(rst_n),
    .input_switch_close(sw_close), .fault_flags(flags),
    .sys_supply_warn_flag(warn), .interrupt_out_n(irq_n),
    .general_pin_out(gp_out), .general_pin_oe_n(gp_oe_n));

  host_model i_host_model (.sys_clk(sys_clk), .read_en(read_en),
    .swpc_go(swpc_go), .interrupt_out_n(irq_n), .fault_flags(flags),
    .fault_read(rd), .sw_power_cycle_req_wr(wr), .i2c_activity(act));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic check(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  // Event codes: 0 outputs on, 1 switch closed, 2 reset low, 3+ state
  function automatic logic probe(input int k);
    case (k)
      0: return oe;
      1: return sw_close;
      2: return !rst_n;
      default: return state === pwr_state_t'(k - 3);
    endcase
  endfunction

  task automatic wait_for(input int k, lo, hi, input string what);
    int i;
    for (i = 1; i <= hi && probe(k) !== 1'b1; i++) @(negedge sys_clk);
    if (i > hi) begin
      fails++;
      $display("ERROR %s expected event seen timeout", what);
      close_out();
    end
    check(i >= lo, 1'b1, what);
  endtask

  // Timings are checked with a margin because timers count 1 ms ticks
  task automatic cycle_seq(input int lo, hi);
    wait_for(6, lo, hi, "cycle off");
    cyc(2);
    check(oe, 1'b0, "cycle outputs off");
    wait_for(7, 493 * MSC, 505 * MSC, "cycle seq");
    cyc(2);
    check(oe, 1'b1, "cycle outputs on");
    wait_for(5, 493 * MSC, 505 * MSC, "cycle on");
  endtask

  initial begin
    sys_rst = 1'b1;
    {pb_n, en, low_imp, rail_low, ocp, ovp, uv, flt} = 8'hc0;
    {sw_ss, buck_lim, buck_cyc, ldo_lim, swpc_go, wsr, wpc} = 7'h00;
    {hold_sel, pin_sel, mask, read_en} = '0;
    fails = 0;
    tests_run = 0;
    cyc(20);
    check(state, PWR_OFF, "reset state");
    check({oe, rst_n, irq_n, req, gp_oe_n}, 8'h6f, "reset outputs");
    check({flags, gp_out}, 11'h000, "reset flags");
    read_en = 1'b1;
    sys_rst = 1'b0;
    // Input switch: retry, soft start masking, overvoltage and undervoltage
    wait_for(1, 18, 30, "switch close");
    sw_ss = 1'b1;
    cyc(5);
    {ocp, sw_ss} = 2'b10;
    cyc(5);
    check(sw_close, 1'b0, "ocp open");
    wait_for(1, 14, 30, "ocp retry");
    cyc(10);
    check(sw_close, 1'b1, "soft start masks ocp");
    {ocp, sw_ss} = 2'b01;
    cyc(5);
    ovp = 1'b1;
    cyc(4);
    ovp = 1'b0;
    cyc(10);
    check(sw_close, 1'b1, "ov glitch ignored");
    ovp = 1'b1;
    cyc(30);
    check(sw_close, 1'b0, "ov holds open");
    ovp = 1'b0;
    wait_for(1, 18, 32, "ov retry");
    uv = 1'b1;
    cyc(5);
    check(sw_close, 1'b0, "uv open");
    uv = 1'b0;
    wait_for(1, 18, 32, "uv retry");
    // Power on: debounce, early release, fault abort, random hold time
    hold_sel = 2'h3;
    pb_n = 1'b0;
    wait_for(4, 1, 6, "start seq");
    wait_for(0, 28, 37, "debounce");
    pb_n = 1'b1;
    wait_for(3, 1, 6, "early release");
    cyc(2);
    check(oe, 1'b0, "release outputs off");
    pb_n = 1'b0;
    wait_for(4, 1, 8, "start seq fault");
    flt = 1'b1;
    wait_for(3, 1, 6, "fault abort");
    {pb_n, flt} = 2'b10;
    cyc(5);
    seed = xs(seed);
    hold_sel = seed[1:0];
    pin_sel = seed[3:2];
    hold = hold_ms[seed[1:0]];
    pb_n = 1'b0;
    wait_for(4, 1, 6, "start seq hold");
    wait_for(5, hold - 2, hold + 6, "hold reached");
    pb_n = 1'b1;
    cyc(20);
    check(oe, 1'b1, "powered on");
    check(irq_n, 1'b1, "press flag read");
    // Rail warning: latched, held until read, masked shows live state
    read_en = 1'b0;
    rail_low = 1'b1;
    cyc(6);
    check(warn, 1'b1, "rail warn flag");
    check(irq_n, 1'b0, "rail warn irq");
    check(oe, 1'b1, "rail warn outputs run");
    rail_low = 1'b0;
    cyc(20);
    check(irq_n, 1'b0, "irq held until read");
    check(warn, 1'b1, "warn latched");
    read_en = 1'b1;
    cyc(20);
    check({irq_n, warn}, 2'b10, "irq released after read");
    mask = 7'h01;
    rail_low = 1'b1;
    cyc(6);
    check({irq_n, warn}, 2'b11, "masked warn live");
    rail_low = 1'b0;
    cyc(6);
    check(warn, 1'b0, "masked warn clears");
    mask = 7'h00;
    // Short press and a frozen clock enable change nothing
    pb_n = 1'b0;
    cyc(100);
    pb_n = 1'b1;
    cyc(10);
    check(state, PWR_ON, "short press ignored");
    en = 1'b0;
    pb_n = 1'b0;
    cyc(20);
    pb_n = 1'b1;
    cyc(5);
    en = 1'b1;
    cyc(5);
    check({state, oe}, {PWR_ON, 1'b1}, "frozen while disabled");
    // Low-impedance presses: soft reset, then power cycle; a normal long press then cycles too
    {pb_n, low_imp} = 2'b01;
    wait_for(2, 1995, 2010, "soft reset");
    cyc(100);
    check(oe, 1'b1, "soft reset keeps outputs");
    pb_n = 1'b1;
    cyc(6);
    check({rst_n, state}, {1'b1, PWR_ON}, "soft reset release");
    pb_n = 1'b0;
    cyc(4100);
    pb_n = 1'b1;
    cycle_seq(1, 8);
    {pb_n, low_imp} = 2'b00;
    cyc(9000);
    pb_n = 1'b1;
    cycle_seq(1, 8);
    // Software power cycle request
    swpc_go = 1'b1;
    cyc(1);
    swpc_go = 1'b0;
    cyc(3);
    check(req, 1'b1, "cycle request set");
    cycle_seq(1, 14);
    cyc(2);
    check(req, 1'b0, "cycle request cleared");
    // Watchdog: soft reset alone, power cycle when both enables set
    check(rst_n, 1'b1, "watchdog off after reset");
    wsr = 1'b1;
    wait_for(2, 7990, 8010, "wdt soft reset");
    cyc(40);
    check({rst_n, state}, {1'b1, PWR_ON}, "wdt soft reset ends");
    wpc = 1'b1;
    cycle_seq(7930, 8010);
    {wsr, wpc} = 2'b00;
    // Regulator current limits and interrupt pin routing
    buck_lim = 1'b1;
    for (int j = 0; j < 10; j++) begin
      buck_cyc = 1'b1;
      cyc(3);
      buck_cyc = 1'b0;
      cyc(3);
      if (j == 5) check(flags[3], 1'b0, "buck six cycles");
    end
    check(flags[3], 1'b1, "buck eight cycles");
    check(irq_n, 1'b0, "buck irq");
    pin_exp = ~(4'h1 << pin_sel);
    check(gp_oe_n, pin_exp, "irq pin drive");
    check(gp_out, 4'h0, "irq pin level");
    buck_lim = 1'b0;
    cyc(30);
    check(irq_n, 1'b1, "buck irq released");
    check(gp_oe_n, 4'hf, "irq pin released");
    ldo_lim = 1'b1;
    cyc(6);
    ldo_lim = 1'b0;
    cyc(5);
    check(flags[4], 1'b0, "ldo short limit");
    ldo_lim = 1'b1;
    cyc(16);
    check(flags[4], 1'b1, "ldo long limit");
    ldo_lim = 1'b0;
    // Twelve second press forces off and stays off
    pb_n = 1'b0;
    wait_for(3, 11995, 12010, "long off");
    cyc(50);
    check(oe, 1'b0, "long off outputs");
    pb_n = 1'b1;
    cyc(10);
    check(state, PWR_OFF, "long off stays");
    close_out();
  end
endmodule

// File: verilog/persist_counter.sv
// Counts steps while a level stays high; reports once the count is reached
`timescale 1ns/1ps
module persist_counter #(
  parameter int W = 16,
  parameter int N = 8
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic level,
  input wire logic step,
  output logic hit
);
  localparam logic [W-1:0] LIM = W'(N);
  logic [W-1:0] cnt_ff;

  // Any drop of the level restarts the count, so only unbroken runs count
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_ff <= '0;
    end else if (clk_en) begin
      if (!level) begin
        cnt_ff <= '0;
      end else if (step && cnt_ff != LIM) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  assign hit = level && (cnt_ff == LIM);

  run_break_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && !level) |=> !hit)
    else $error("persist hit survived a break in the level");
endmodule

// File: verilog/pmic_system_supervisor.sv
// Pushbutton, power cycle, input switch, watchdog and fault flag logic
`timescale 1ns/1ps
`include "supervisor_params.svh"
module pmic_system_supervisor import supervisor_pkg::*; #(
  parameter int CW = 14,
  parameter int MS_CYCLES = `MS_CYCLES,
  parameter int OV_DEGLITCH_CYC = `OV_DEGLITCH_CYC,
  parameter int LDO_ILIM_CYC = `LDO_ILIM_CYC,
  parameter int BUCK_ILIM_CYCLES = `BUCK_ILIM_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pushbutton_in_n,
  input wire logic press_low_imp,
  input wire logic system_rail_below_warn,
  input wire logic vin_overcurrent,
  input wire logic vin_overvoltage,
  input wire logic vin_undervoltage,
  input wire logic input_switch_ss_done,
  input wire logic buck_ilim,
  input wire logic buck_sw_cycle,
  input wire logic buck_ss_done,
  input wire logic ldo_ilim,
  input wire logic ldo_ss_done,
  input wire logic output_fault,
  input wire logic [1:0] press_hold_time_sel,
  input wire logic sw_power_cycle_req_wr,
  input wire logic wdt_soft_reset_en,
  input wire logic wdt_power_cycle_en,
  input wire logic i2c_activity,
  input wire logic [`NUM_FAULTS-1:0] fault_mask,
  input wire logic [`NUM_FAULTS-1:0] fault_read,
  input wire logic [1:0] irq_pin_sel,
  output logic sw_power_cycle_req,
  output pwr_state_t power_state,
  output logic outputs_enable,
  output logic system_reset_out_n,
  output logic input_switch_close,
  output logic [`NUM_FAULTS-1:0] fault_flags,
  output logic sys_supply_warn_flag,
  output logic interrupt_out_n,
  output logic [3:0] general_pin_out,
  output logic [3:0] general_pin_oe_n
);
  localparam int NA = 13;
  localparam int NF = `NUM_FAULTS;
  localparam logic [CW-1:0] DEB = CW'(`DEBOUNCE_MS);
  localparam logic [CW-1:0] HOLD0 = CW'(`HOLD0_MS);
  localparam logic [CW-1:0] HOLD1 = CW'(`HOLD1_MS);
  localparam logic [CW-1:0] HOLD2 = CW'(`HOLD2_MS);
  localparam logic [CW-1:0] HOLD3 = CW'(`HOLD3_MS);
  localparam logic [CW-1:0] PC1_MIN = CW'(`PC1_MIN_MS);
  localparam logic [CW-1:0] PC1_MAX = CW'(`PC1_MAX_MS);
  localparam logic [CW-1:0] SRST_MIN = CW'(`SRST_MIN_MS);
  localparam logic [CW-1:0] PC2_MIN = CW'(`PC2_MIN_MS);
  localparam logic [CW-1:0] CYC_OFF = CW'(`CYC_OFF_MS);
  localparam logic [CW-1:0] CYC_SEQ = CW'(`CYC_SEQ_MS);
  localparam logic [CW-1:0] SWPC_WAIT = CW'(`SWPC_WAIT_MS);
  localparam logic [CW-1:0] RETRY = CW'(`RETRY_MS);
  localparam logic [CW-1:0] WDT_LIM = CW'(`WDT_MS);
  localparam logic [CW-1:0] WDT_RST = CW'(`WDT_RST_MS);
  localparam logic [15:0] TICK_LAST = 16'(MS_CYCLES - 1);

  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  // Two-stage synchronisers for every analog-side level
  logic [NA-1:0] a_in, s1_ff, s2_ff;
  assign a_in = {output_fault, ldo_ss_done, ldo_ilim, buck_ss_done,
                 buck_sw_cycle, buck_ilim, input_switch_ss_done,
                 vin_undervoltage, vin_overvoltage, vin_overcurrent,
                 system_rail_below_warn, press_low_imp, pushbutton_in_n};
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_ff <= `SYNC_RESET;
      s2_ff <= `SYNC_RESET;
    end else if (clk_en) begin
      s1_ff <= a_in;
      s2_ff <= s1_ff;
    end
  end
  wire pressed = !s2_ff[0];
  wire lowz_s = s2_ff[1];
  wire warn_s = s2_ff[2];
  wire ocp_s = s2_ff[3];
  wire ov_s = s2_ff[4];
  wire uv_s = s2_ff[5];
  wire sw_ss_s = s2_ff[6];
  wire buck_lim_s = s2_ff[7];
  wire buck_cyc_s = s2_ff[8];
  wire buck_ss_s = s2_ff[9];
  wire ldo_lim_s = s2_ff[10];
  wire ldo_ss_s = s2_ff[11];
  wire fault_s = s2_ff[12];

  // Millisecond timebase shared by all press and state timers
  logic [15:0] pre_ff;
  wire tick = (pre_ff == TICK_LAST);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) pre_ff <= 16'h0000;
    else if (clk_en) pre_ff <= tick ? 16'h0000 : pre_ff + 16'h0001;
  end

  // Press timing; the class is caught at the press edge
  logic pb_prev_ff, lowz_ff, block_ff;
  logic [CW-1:0] press_ms_ff;
  wire press_start = pressed && !pb_prev_ff;
  wire press_end = !pressed && pb_prev_ff;
  wire [CW-1:0] hold_ms = (press_hold_time_sel == 2'h0) ? HOLD0 :
                          (press_hold_time_sel == 2'h1) ? HOLD1 :
                          (press_hold_time_sel == 2'h2) ? HOLD2 : HOLD3;
  wire ev_off12 = pressed && !lowz_ff && !block_ff &&
                  press_ms_ff >= PC1_MAX;
  wire ev_pc1 = press_end && !lowz_ff && !block_ff &&
                press_ms_ff > PC1_MIN && press_ms_ff < PC1_MAX;
  wire ev_pc2 = press_end && lowz_ff && press_ms_ff > PC2_MIN;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pb_prev_ff <= 1'b0;
      lowz_ff <= 1'b0;
      block_ff <= 1'b0;
      press_ms_ff <= '0;
    end else if (clk_en) begin
      pb_prev_ff <= pressed;
      if (press_start) lowz_ff <= lowz_s;
      // A forced off stays latched until the button is let go
      block_ff <= ev_off12 | (block_ff & !press_end);
      if (press_start) press_ms_ff <= '0;
      else if (pressed && tick) press_ms_ff <= sat_inc(press_ms_ff);
    end
  end

  // Watchdog
  logic [CW-1:0] wdt_ms_ff, wrst_ms_ff;
  wire wdt_on = wdt_soft_reset_en | wdt_power_cycle_en;
  wire wdt_exp = wdt_on && tick && wdt_ms_ff == WDT_LIM;
  wire ev_wdt_pc = wdt_exp && wdt_power_cycle_en;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wdt_ms_ff <= '0;
      wrst_ms_ff <= '0;
    end else if (clk_en) begin
      if (!wdt_on || i2c_activity || wdt_exp) wdt_ms_ff <= '0;
      else if (tick) wdt_ms_ff <= sat_inc(wdt_ms_ff);
      if (wdt_exp && !wdt_power_cycle_en) wrst_ms_ff <= WDT_RST;
      else if (tick && wrst_ms_ff != '0) wrst_ms_ff <= wrst_ms_ff - 1'b1;
    end
  end

  // Software power cycle request
  logic swpc_req_ff, swpc_busy_ff;
  logic [CW-1:0] swpc_ms_ff;
  wire ev_swpc = swpc_req_ff && !swpc_busy_ff && swpc_ms_ff >= SWPC_WAIT;
  wire cycle_go = ev_pc1 | ev_pc2 | ev_swpc | ev_wdt_pc;

  // Power state machine
  pwr_state_t pwr_state_ff, nxt_pwr_state;
  logic [CW-1:0] state_ms_ff;
  always_comb begin
    nxt_pwr_state = pwr_state_ff;
    if (ev_off12) begin
      nxt_pwr_state = PWR_OFF;
    end else if (cycle_go) begin
      nxt_pwr_state = PWR_CYC_OFF;
    end else begin
      case (pwr_state_ff)
        PWR_OFF: begin
          if (press_start && !lowz_s) nxt_pwr_state = PWR_START_SEQ;
        end
        PWR_START_SEQ: begin
          if (!pressed || fault_s) nxt_pwr_state = PWR_OFF;
          else if (press_ms_ff > hold_ms) nxt_pwr_state = PWR_ON;
        end
        PWR_ON: nxt_pwr_state = PWR_ON;
        PWR_CYC_OFF: begin
          if (state_ms_ff >= CYC_OFF) nxt_pwr_state = PWR_CYC_SEQ;
        end
        PWR_CYC_SEQ: begin
          if (state_ms_ff >= CYC_SEQ) nxt_pwr_state = PWR_ON;
        end
        default: nxt_pwr_state = PWR_OFF;
      endcase
    end
  end
  wire swpc_done = swpc_busy_ff && pwr_state_ff == PWR_CYC_SEQ &&
                   nxt_pwr_state == PWR_ON;
  // Outputs start only after the debounce in the start sequence
  wire en_now = (pwr_state_ff == PWR_ON) || (pwr_state_ff == PWR_CYC_SEQ) ||
                (pwr_state_ff == PWR_START_SEQ && state_ms_ff >= DEB);
  wire rst_low = (pressed && lowz_ff && press_ms_ff >= SRST_MIN) ||
                 (wrst_ms_ff != '0);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pwr_state_ff <= PWR_OFF;
      state_ms_ff <= '0;
      outputs_enable <= 1'b0;
      system_reset_out_n <= 1'b1;
      swpc_req_ff <= 1'b0;
      swpc_busy_ff <= 1'b0;
      swpc_ms_ff <= '0;
    end else if (clk_en) begin
      pwr_state_ff <= nxt_pwr_state;
      if (nxt_pwr_state != pwr_state_ff) state_ms_ff <= '0;
      else if (tick) state_ms_ff <= sat_inc(state_ms_ff);
      outputs_enable <= en_now;
      system_reset_out_n <= !rst_low;
      // A new write in the clearing cycle wins and starts another cycle
      swpc_req_ff <= sw_power_cycle_req_wr | (swpc_req_ff & !swpc_done);
      swpc_busy_ff <= !swpc_done & (swpc_busy_ff | ev_swpc);
      if (!swpc_req_ff || swpc_busy_ff) swpc_ms_ff <= '0;
      else if (tick) swpc_ms_ff <= sat_inc(swpc_ms_ff);
    end
  end
  assign power_state = pwr_state_ff;
  assign sw_power_cycle_req = swpc_req_ff;

  // Input smart switch sequencing
  logic ov_fault, buck_hit, ldo_hit, buck_cyc_prev_ff;
  persist_counter #(.W(CW), .N(OV_DEGLITCH_CYC)) u_ov_deglitch (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .level(ov_s), .step(1'b1), .hit(ov_fault));
  persist_counter #(.W(4), .N(BUCK_ILIM_CYCLES)) u_buck_ilim (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .level(buck_lim_s && buck_ss_s),
    .step(buck_cyc_s && !buck_cyc_prev_ff), .hit(buck_hit));
  persist_counter #(.W(11), .N(LDO_ILIM_CYC + 1)) u_ldo_ilim (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .level(ldo_lim_s && ldo_ss_s), .step(1'b1), .hit(ldo_hit));

  sw_state_t sw_state_ff, nxt_sw_state;
  logic [CW-1:0] sw_ms_ff;
  wire in_hold = ov_fault || uv_s;
  always_comb begin
    nxt_sw_state = sw_state_ff;
    if (in_hold) begin
      nxt_sw_state = SW_HOLD;
    end else begin
      case (sw_state_ff)
        SW_RETRY: if (sw_ms_ff >= RETRY) nxt_sw_state = SW_SOFT;
        SW_SOFT: if (sw_ss_s) nxt_sw_state = SW_CLOSED;
        SW_CLOSED: if (ocp_s) nxt_sw_state = SW_RETRY;
        SW_HOLD: nxt_sw_state = SW_RETRY;
        default: nxt_sw_state = SW_RETRY;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sw_state_ff <= SW_RETRY;
      sw_ms_ff <= '0;
      input_switch_close <= 1'b0;
      buck_cyc_prev_ff <= 1'b0;
    end else if (clk_en) begin
      sw_state_ff <= nxt_sw_state;
      if (nxt_sw_state != sw_state_ff) sw_ms_ff <= '0;
      else if (tick) sw_ms_ff <= sat_inc(sw_ms_ff);
      input_switch_close <= (nxt_sw_state == SW_SOFT) ||
                            (nxt_sw_state == SW_CLOSED);
      buck_cyc_prev_ff <= buck_cyc_s;
    end
  end

  // Fault flags and interrupt
  logic [NF-1:0] fault_live, fault_latch;
  assign fault_live[`FLT_SYS_WARN] = warn_s;
  assign fault_live[`FLT_IN_OCP] = ocp_s && sw_state_ff == SW_CLOSED;
  assign fault_live[`FLT_IN_OVP] = ov_fault;
  assign fault_live[`FLT_BUCK_ILIM] = buck_hit;
  assign fault_live[`FLT_LDO_ILIM] = ldo_hit;
  assign fault_live[`FLT_WDT] = wdt_exp;
  assign fault_live[`FLT_PRESS] = press_start;

  genvar g;
  generate
    for (g = 0; g < NF; g++) begin : g_flag
      logic latch_ff, seen_ff;
      wire set = fault_live[g] && !fault_mask[g];
      wire clr = !fault_live[g] && (fault_read[g] || seen_ff);
      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          latch_ff <= 1'b0;
          seen_ff <= 1'b0;
        end else if (clk_en) begin
          latch_ff <= set | (latch_ff & !clr);
          seen_ff <= !set & latch_ff & !clr & (seen_ff | fault_read[g]);
        end
      end
      assign fault_latch[g] = latch_ff;
    end
  endgenerate

  logic irq_ff;
  wire irq_any = |(fault_latch & ~fault_mask);
  wire [3:0] pin_hot = 4'h1 << irq_pin_sel;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fault_flags <= '0;
      irq_ff <= 1'b0;
      general_pin_oe_n <= 4'hf;
    end else if (clk_en) begin
      fault_flags <= (fault_mask & fault_live) |
                     (~fault_mask & fault_latch);
      irq_ff <= irq_any;
      general_pin_oe_n <= ~({4{irq_any}} & pin_hot);
    end
  end
  assign interrupt_out_n = !irq_ff;
  assign sys_supply_warn_flag = fault_flags[`FLT_SYS_WARN];
  assign general_pin_out = 4'h0;

  warn_irq_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (warn_s && !fault_mask[`FLT_SYS_WARN]) ##1 fault_latch[`FLT_SYS_WARN]
    |=> !interrupt_out_n)
    else $error("rail warning did not assert interrupt");
  debounce_wait_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (pwr_state_ff == PWR_START_SEQ && state_ms_ff < DEB) |=> !outputs_enable)
    else $error("outputs enabled before debounce");
  hold_reach_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (pwr_state_ff == PWR_START_SEQ ##1 pwr_state_ff == PWR_ON)
    |-> $past(press_ms_ff) > $past(hold_ms))
    else $error("powered on before hold time");
  early_off_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (pwr_state_ff == PWR_START_SEQ && (!pressed || fault_s) && !cycle_go)
    |=> pwr_state_ff == PWR_OFF ##1 !outputs_enable)
    else $error("early release did not power off");
  cycle_off_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (pwr_state_ff == PWR_CYC_OFF && state_ms_ff < CYC_OFF && !ev_off12)
    |=> pwr_state_ff == PWR_CYC_OFF)
    else $error("cycle off phase shorter than set");
  short_press_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (press_end && !lowz_ff && press_ms_ff <= PC1_MIN &&
     pwr_state_ff == PWR_ON && !ev_swpc && !ev_wdt_pc)
    |=> pwr_state_ff == PWR_ON)
    else $error("short press caused an action");
  long_off_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    ev_off12 |=> pwr_state_ff == PWR_OFF ##1 !outputs_enable)
    else $error("twelve second press did not power off");
  soft_rst_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (pressed && lowz_ff && press_ms_ff >= SRST_MIN) |=> !system_reset_out_n)
    else $error("soft reset not asserted");
  wdt_cycle_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (ev_wdt_pc && !ev_off12) |=> pwr_state_ff == PWR_CYC_OFF)
    else $error("watchdog expiry did not cycle power");
  ocp_open_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (sw_state_ff == SW_CLOSED && ocp_s) |=> !input_switch_close)
    else $error("switch stayed closed on overcurrent");
  irq_hold_a: assert property (@(posedge sys_clk)
    disable iff (sys_rst || !clk_en)
    (|(fault_latch & fault_live & ~fault_mask)) |=> !interrupt_out_n)
    else $error("interrupt released while fault present");
endmodule

// File: verilog/supervisor_params.svh
// Timing counts, field positions and reset values of the system supervisor
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

`define CLK_PERIOD_NS 25
`define NS_PER_MS 1000000
`define NS_PER_US 1000
`define MS_CYCLES (`NS_PER_MS / `CLK_PERIOD_NS)

`define DEBOUNCE_MS 32
`define HOLD0_MS 32
`define HOLD1_MS 500
`define HOLD2_MS 1000
`define HOLD3_MS 2000
`define PC1_MIN_MS 8000
`define PC1_MAX_MS 12000
`define SRST_MIN_MS 2000
`define PC2_MIN_MS 4000
`define CYC_OFF_MS 500
`define CYC_SEQ_MS 500
`define SWPC_WAIT_MS 8
`define RETRY_MS 20
`define WDT_MS 8000
`define WDT_RST_MS 20

`define OV_DEGLITCH_US 200
`define OV_DEGLITCH_CYC \
  ((`OV_DEGLITCH_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LDO_ILIM_US 20
`define LDO_ILIM_CYC ((`LDO_ILIM_US * `NS_PER_US) / `CLK_PERIOD_NS)
`define BUCK_ILIM_CYCLES 8

`define NUM_FAULTS 7
`define FLT_SYS_WARN 0
`define FLT_IN_OCP 1
`define FLT_IN_OVP 2
`define FLT_BUCK_ILIM 3
`define FLT_LDO_ILIM 4
`define FLT_WDT 5
`define FLT_PRESS 6

`define IRQ_PIN_RESET 2'h0
`define SYNC_RESET 13'h0001

`endif

// File: verilog/supervisor_pkg.sv
// Types shared by the system supervisor
package supervisor_pkg;
  typedef enum logic [2:0] {
    PWR_OFF       = 3'h0,
    PWR_START_SEQ = 3'h1,
    PWR_ON        = 3'h2,
    PWR_CYC_OFF   = 3'h3,
    PWR_CYC_SEQ   = 3'h4
  } pwr_state_t;

  typedef enum logic [1:0] {
    SW_RETRY  = 2'h0,
    SW_SOFT   = 2'h1,
    SW_CLOSED = 2'h2,
    SW_HOLD   = 2'h3
  } sw_state_t;
endpackage
